// File: rtl/ram_pkg.sv
package ram_pkg;
  localparam int unsigned ADDR_W           = 8;
  localparam int unsigned DATA_W           = 16;
  localparam logic [7:0]  OFF_SEC_MIN      = 8'h14;
  localparam logic [7:0]  OFF_HRS_DAY      = 8'h15;
  localparam logic [7:0]  OFF_DATE_MTH     = 8'h16;
  localparam logic [7:0]  OFF_TIME_CTRL    = 8'h17;
  localparam logic [7:0]  OFF_IRQ_STATUS   = 8'h18;
  localparam logic [7:0]  OFF_IRQ_MASK     = 8'h19;
  localparam int unsigned MIN_LSB          = 8;
  localparam int unsigned SEC_LSB          = 0;
  localparam int unsigned DAY_LSB          = 8;
  localparam int unsigned PM_BIT           = 5;
  localparam int unsigned HRS_LSB          = 0;
  localparam int unsigned MTH_LSB          = 8;
  localparam int unsigned DATE_LSB         = 0;
  localparam int unsigned TWELVE_BIT       = 14;
  localparam int unsigned STOP_BIT         = 9;
  localparam int unsigned STOPPED_BIT      = 8;
  localparam logic [15:0] SEC_MIN_MASK     = 16'h7F7F;
  localparam logic [15:0] HRS_DAY_MASK     = 16'h0F3F;
  localparam logic [15:0] DATE_MTH_MASK    = 16'h1F3F;
  localparam logic [15:0] TIME_CTRL_WMASK  = 16'h4200;
  localparam logic [15:0] SEC_MIN_RESET    = 16'h0000;
  localparam logic [15:0] HRS_DAY_RESET    = 16'h0000;
  localparam logic [15:0] DATE_MTH_RESET   = 16'h0000;
  localparam logic [15:0] TIME_CTRL_RESET  = 16'h0000;
  localparam logic        IRQ_RESET        = 1'b0;
  localparam logic [1:0]  STOP_SYNC_RESET  = 2'b00;
endpackage : ram_pkg

// File: rtl/ram_time_if.sv
`timescale 1ns/100ps
interface ram_time_if;
  logic [6:0] sec;
  logic [6:0] min;
  logic [4:0] hrs;
  logic       pm;
  logic [3:0] day;
  logic [5:0] date;
  logic [4:0] mth;
  logic       twelve;
  modport src (output sec, output min, output hrs, output pm, output day, output date, output mth, output twelve);
  modport dst (input sec, input min, input hrs, input pm, input day, input date, input mth, input twelve);
endinterface : ram_time_if

// File: rtl/ram_field_match.sv
`timescale 1ns/100ps
module ram_field_match #(
  parameter int unsigned W = 7
) (
  input  wire logic [W-1:0] alarm_val,
  input  wire logic [W-1:0] time_val,
  output logic              hit
);
  // refused at elaboration: a zero-width field has no all-ones code
  if (W < 1) begin : g_bad_width
    $error("ram_field_match: W must be at least 1");
  end
  always_comb begin
    hit = (&alarm_val) || (alarm_val == time_val);
  end
endmodule : ram_field_match

// File: rtl/ram_alarm_match.sv
// Operation
// - minutes alarm bits 14:8, all ones ignored
// - seconds alarm bits 6:0, all ones ignored
// - weekday alarm bits 11:8, all ones ignored
// - afternoon flag bit 5, twelve-hour only
// - hours alarm bits 4:0, all ones ignored
// - month alarm bits 12:8, all ones ignored
// - date alarm bits 5:0, all ones ignored
// - alarm held while all fields match
// - date and month ignored give weekly one-second alarm
// - stop bit 9 suppresses all alarm events
// - stopped status bit 8 reports real state
// - full match raises the alarm event
// - bit 14 selects twelve-hour format
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
module ram_alarm_match (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic [ram_pkg::ADDR_W-1:0]  addr,
  input  wire logic [ram_pkg::DATA_W-1:0]  wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  input  wire logic [6:0]                  time_sec,
  input  wire logic [6:0]                  time_min,
  input  wire logic [4:0]                  time_hrs,
  input  wire logic                        time_pm,
  input  wire logic [3:0]                  time_day,
  input  wire logic [5:0]                  time_date,
  input  wire logic [4:0]                  time_mth,
  output logic [ram_pkg::DATA_W-1:0]       rdata,
  output logic                             alarm_event,
  output logic                             twelve_hour_select,
  output logic                             irq
);
  logic [15:0] sec_min_reg;
  logic [15:0] sec_min_next;
  logic [15:0] hrs_day_reg;
  logic [15:0] hrs_day_next;
  logic [15:0] date_mth_reg;
  logic [15:0] date_mth_next;
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [1:0]  stop_sync_reg;
  logic [1:0]  stop_sync_next;
  logic        alarm_event_reg;
  logic        alarm_event_next;
  logic        irq_status_reg;
  logic        irq_status_next;
  logic        irq_mask_reg;
  logic        irq_mask_next;
  logic        irq_reg;
  logic        irq_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic        hit_sec;
  logic        hit_min;
  logic        hit_hrs;
  logic        hit_day;
  logic        hit_date;
  logic        hit_mth;
  logic        hit_pm;
  logic        all_hit;
  logic        stopped;
  logic        event_rise;

  ram_time_if tif ();

  assign tif.sec    = time_sec;
  assign tif.min    = time_min;
  assign tif.hrs    = time_hrs;
  assign tif.pm     = time_pm;
  assign tif.day    = time_day;
  assign tif.date   = time_date;
  assign tif.mth    = time_mth;
  assign tif.twelve = ctrl_reg[ram_pkg::TWELVE_BIT];

  ram_field_match #(.W(7)) u_sec (
    .alarm_val (sec_min_reg[ram_pkg::SEC_LSB +: 7]),
    .time_val  (tif.sec),
    .hit       (hit_sec)
  );
  ram_field_match #(.W(7)) u_min (
    .alarm_val (sec_min_reg[ram_pkg::MIN_LSB +: 7]),
    .time_val  (tif.min),
    .hit       (hit_min)
  );
  ram_field_match #(.W(5)) u_hrs (
    .alarm_val (hrs_day_reg[ram_pkg::HRS_LSB +: 5]),
    .time_val  (tif.hrs),
    .hit       (hit_hrs)
  );
  ram_field_match #(.W(4)) u_day (
    .alarm_val (hrs_day_reg[ram_pkg::DAY_LSB +: 4]),
    .time_val  (tif.day),
    .hit       (hit_day)
  );
  ram_field_match #(.W(6)) u_date (
    .alarm_val (date_mth_reg[ram_pkg::DATE_LSB +: 6]),
    .time_val  (tif.date),
    .hit       (hit_date)
  );
  ram_field_match #(.W(5)) u_mth (
    .alarm_val (date_mth_reg[ram_pkg::MTH_LSB +: 5]),
    .time_val  (tif.mth),
    .hit       (hit_mth)
  );

  always_comb begin
    // afternoon flag only counts in twelve-hour mode, and not when hours are ignored
    hit_pm = !tif.twelve || (&hrs_day_reg[ram_pkg::HRS_LSB +: 5]) ||
             (hrs_day_reg[ram_pkg::PM_BIT] == tif.pm);
    all_hit = hit_sec && hit_min && hit_hrs && hit_pm && hit_day && hit_date && hit_mth;
    stopped = stop_sync_reg[1];
  end

  // register file
  always_comb begin
    sec_min_next  = sec_min_reg;
    hrs_day_next  = hrs_day_reg;
    date_mth_next = date_mth_reg;
    ctrl_next     = ctrl_reg;
    irq_mask_next = irq_mask_reg;
    rdata_next    = 16'h0000;
    if (wr) begin
      unique case (addr)
        ram_pkg::OFF_SEC_MIN:   sec_min_next  = wdata & ram_pkg::SEC_MIN_MASK;
        ram_pkg::OFF_HRS_DAY:   hrs_day_next  = wdata & ram_pkg::HRS_DAY_MASK;
        ram_pkg::OFF_DATE_MTH:  date_mth_next = wdata & ram_pkg::DATE_MTH_MASK;
        ram_pkg::OFF_TIME_CTRL: ctrl_next     = wdata & ram_pkg::TIME_CTRL_WMASK;
        ram_pkg::OFF_IRQ_MASK:  irq_mask_next = wdata[0];
        default: ;
      endcase
    end
    if (rd) begin
      unique case (addr)
        ram_pkg::OFF_SEC_MIN:    rdata_next = sec_min_reg;
        ram_pkg::OFF_HRS_DAY:    rdata_next = hrs_day_reg;
        ram_pkg::OFF_DATE_MTH:   rdata_next = date_mth_reg;
        ram_pkg::OFF_TIME_CTRL: begin
          rdata_next = ctrl_reg;
          rdata_next[ram_pkg::STOPPED_BIT] = stopped;
        end
        ram_pkg::OFF_IRQ_STATUS: rdata_next = {15'h0000, irq_status_reg};
        ram_pkg::OFF_IRQ_MASK:   rdata_next = {15'h0000, irq_mask_reg};
        default:                 rdata_next = 16'h0000;
      endcase
    end
  end

  // alarm path: stop request walks two stages so status reflects the gated path
  always_comb begin
    stop_sync_next   = {stop_sync_reg[0], ctrl_reg[ram_pkg::STOP_BIT]};
    alarm_event_next = all_hit && !ctrl_reg[ram_pkg::STOP_BIT] && !stopped;
    event_rise       = alarm_event_next && !alarm_event_reg;
    irq_status_next  = irq_status_reg;
    if (wr && addr == ram_pkg::OFF_IRQ_STATUS && wdata[0]) begin
      irq_status_next = 1'b0;
    end
    if (event_rise) begin
      irq_status_next = 1'b1;
    end
    irq_next = irq_status_next && irq_mask_next;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sec_min_reg     <= ram_pkg::SEC_MIN_RESET;
      hrs_day_reg     <= ram_pkg::HRS_DAY_RESET;
      date_mth_reg    <= ram_pkg::DATE_MTH_RESET;
      ctrl_reg        <= ram_pkg::TIME_CTRL_RESET;
      stop_sync_reg   <= ram_pkg::STOP_SYNC_RESET;
      alarm_event_reg <= ram_pkg::IRQ_RESET;
      irq_status_reg  <= ram_pkg::IRQ_RESET;
      irq_mask_reg    <= ram_pkg::IRQ_RESET;
      irq_reg         <= ram_pkg::IRQ_RESET;
      rdata_reg       <= 16'h0000;
    end else begin
      sec_min_reg     <= sec_min_next;
      hrs_day_reg     <= hrs_day_next;
      date_mth_reg    <= date_mth_next;
      ctrl_reg        <= ctrl_next;
      stop_sync_reg   <= stop_sync_next;
      alarm_event_reg <= alarm_event_next;
      irq_status_reg  <= irq_status_next;
      irq_mask_reg    <= irq_mask_next;
      irq_reg         <= irq_next;
      rdata_reg       <= rdata_next;
    end
  end

  assign rdata              = rdata_reg;
  assign alarm_event        = alarm_event_reg;
  assign twelve_hour_select = ctrl_reg[ram_pkg::TWELVE_BIT];
  assign irq                = irq_reg;
endmodule : ram_alarm_match

// File: testbench/ram_alarm_match_props.sv
`timescale 1ns/100ps
module ram_alarm_match_props (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        alarm_event,
  input wire logic        twelve_hour_select,
  input wire logic        irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_stop; wr && addr == 8'h17 && wdata[9]; endsequence
  sequence s_rdc; rd && addr == 8'h17; endsequence
  property p_sm; rd && addr == 8'h14 |=> (rdata & 16'h8080) == 16'h0000; endproperty
  a_sm: assert property (p_sm) else $error("sec min read");
  property p_hd; rd && addr == 8'h15 |=> (rdata & 16'hF0C0) == 16'h0000; endproperty
  a_hd: assert property (p_hd) else $error("hour day read");
  property p_dm; rd && addr == 8'h16 |=> (rdata & 16'hE0C0) == 16'h0000; endproperty
  a_dm: assert property (p_dm) else $error("date month read");
  property p_ctl; s_rdc |=> (rdata & 16'hBCFF) == 16'h0000; endproperty
  a_ctl: assert property (p_ctl) else $error("ctrl read");
  property p_twelve; wr && addr == 8'h17 |=> twelve_hour_select == $past(wdata[14]); endproperty
  a_twelve: assert property (p_twelve) else $error("hour format");
  property p_stop; s_stop |-> ##2 !alarm_event; endproperty
  a_stop: assert property (p_stop) else $error("alarm not stopped");
  property p_stopped; s_stop ##1 (!wr)[*4] ##0 s_rdc |=> rdata[8]; endproperty
  a_stopped: assert property (p_stopped) else $error("stopped status");
  // mask write reaches irq on the same edge that loads the mask
  property p_irq; $rose(irq) |-> $rose(alarm_event) || ($past(wr) && $past(addr) == 8'h19)
    || ($past(wr, 2) && $past(addr, 2) == 8'h19); endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
endmodule : ram_alarm_match_props
bind ram_alarm_match ram_alarm_match_props u_ram_alarm_match_props (.clk, .reset, .addr, .wdata, .wr, .rd,
  .rdata, .alarm_event, .twelve_hour_select, .irq);

// File: testbench/ram_alarm_match_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; $display("unexpected %0t bad", $time); end end
module ram_alarm_match_tb;
  logic        clk = 1'b0;
  logic        reset, wr, rd, time_pm, alarm_event, twelve_hour_select, irq;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata;
  logic [34:0] tv;
  logic [6:0]  time_sec, time_min;
  logic [5:0]  time_date;
  logic [4:0]  time_hrs, time_mth;
  logic [3:0]  time_day;
  int          num_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  localparam logic [34:0] BASE = {7'h05, 7'h0A, 5'h0E, 1'b0, 4'h3, 6'h14, 5'h06};
  assign {time_sec, time_min, time_hrs, time_pm, time_day, time_date, time_mth} = tv;
  ram_alarm_match u_ram_alarm_match (.clk, .reset, .addr, .wdata, .wr, .rd, .time_sec, .time_min, .time_hrs,
    .time_pm, .time_day, .time_date, .time_mth, .rdata, .alarm_event, .twelve_hour_select, .irq);
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (num_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // one strobe cycle; read data sampled just after the answering edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    {wr, rd, addr, wdata} <= {w, !w, a, v};
    @(posedge clk);
    {wr, rd} <= 2'b00;
    #1;
  endtask : bus
  task automatic set_t(input logic [34:0] v);
    @(posedge clk);
    tv <= v;
    repeat (3) @(posedge clk);
    #1;
  endtask : set_t
  task automatic t_stop();
    bus(1, 8'h17, 16'h0200);
    for (int i = 0; i < 8 && rdata[8] !== 1'b1; i++)
      bus(0, 8'h17, 16'h0000);
    `CHK(rdata, 16'h0300)
    `CHK(alarm_event, 1'b0)
    bus(1, 8'h14, 16'h0A05);
    bus(1, 8'h15, 16'h030E);
    bus(1, 8'h16, 16'h0614);
    bus(1, 8'h17, 16'h0000);
    set_t(BASE);
    `CHK(alarm_event, 1'b1)
    bus(0, 8'h17, 16'h0000);
    `CHK(rdata, 16'h0000)
  endtask : t_stop
  task automatic t_fields();
    int          pos [6] = '{28, 21, 16, 11, 5, 0};
    logic [15:0] ign [6] = '{16'h0A7F, 16'h7F05, 16'h033F, 16'h0F0E, 16'h063F, 16'h1F14};
    logic [15:0] val [3] = '{16'h0A05, 16'h030E, 16'h0614};
    for (int i = 0; i < 6; i++) begin
      set_t(BASE ^ (35'd1 << pos[i]));
      `CHK(alarm_event, 1'b0)
      bus(1, 8'h14 + 8'(i / 2), ign[i]);
      bus(0, 8'h14 + 8'(i / 2), 16'h0000);
      `CHK(rdata, ign[i])
      set_t(BASE ^ (35'd1 << pos[i]));
      `CHK(alarm_event, 1'b1)
      bus(1, 8'h14 + 8'(i / 2), val[i / 2]);
    end
    // six low ones are not all ones: seconds must still be compared
    bus(1, 8'h14, 16'h0A3F);
    set_t(BASE);
    `CHK(alarm_event, 1'b0)
    bus(1, 8'h14, 16'h0A05);
    set_t(BASE ^ (35'd1 << 15));
    `CHK(alarm_event, 1'b1)
  endtask : t_fields
  task automatic t_twelve();
    bus(1, 8'h17, 16'h4000);
    set_t(BASE ^ (35'd1 << 15));
    `CHK(twelve_hour_select, 1'b1)
    `CHK(alarm_event, 1'b0)
    bus(1, 8'h15, 16'h032E);
    set_t(BASE ^ (35'd1 << 15));
    `CHK(alarm_event, 1'b1)
    bus(1, 8'h15, 16'h030E);
    bus(1, 8'h17, 16'h0000);
    set_t(BASE);
    `CHK(twelve_hour_select, 1'b0)
  endtask : t_twelve
  task automatic t_irq();
    bus(1, 8'h18, 16'h0001);
    bus(0, 8'h18, 16'h0000);
    `CHK(rdata, 16'h0000)
    bus(1, 8'h19, 16'h0001);
    set_t(BASE ^ 35'd1);
    `CHK(irq, 1'b0)
    set_t(BASE);
    `CHK(irq, 1'b1)
    bus(1, 8'h19, 16'h0000);
    set_t(BASE);
    `CHK(irq, 1'b0)
    bus(0, 8'h18, 16'h0000);
    `CHK(rdata, 16'h0001)
    bus(0, 8'h1A, 16'h0000);
    `CHK(rdata, 16'h0000)
  endtask : t_irq
  task automatic t_set_wins();
    bus(1, 8'h19, 16'h0001);
    set_t(BASE ^ 35'h000000001);
    bus(1, 8'h18, 16'h0001);
    `CHK(irq, 1'b0)
    // clear strobe and alarm rise land on the same edge
    @(posedge clk);
    {wr, addr, wdata, tv} <= {1'b1, 8'h18, 16'h0001, BASE};
    @(posedge clk);
    wr <= 1'b0;
    #1;
    `CHK(irq, 1'b1)
    bus(1, 8'h17, 16'h0200);
    set_t(BASE ^ 35'h000000001);
    bus(1, 8'h18, 16'h0001);
    set_t(BASE);
    `CHK(alarm_event, 1'b0)
    `CHK(irq, 1'b0)
    bus(1, 8'h17, 16'h0000);
    set_t(BASE);
    `CHK(alarm_event, 1'b1)
    `CHK(irq, 1'b1)
  endtask : t_set_wins
  initial begin
    {reset, wr, rd, addr, wdata, tv} <= {1'b1, 61'h0};
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_stop();
    t_fields();
    t_twelve();
    t_irq();
    t_set_wins();
    wrap_up();
  end
endmodule : ram_alarm_match_tb
